// *** src/tpps_defines.svh ***
// Offsets, field positions, reset values and thresholds of the profile select block.
`ifndef TPPS_DEFINES_SVH
`define TPPS_DEFINES_SVH
`define TPPS_ADDR_W 16
`define TPPS_DATA_W 8
`define TPPS_ADDR_PRIO_EN 16'h1600
`define TPPS_ADDR_SOURCE 16'h1601
`define TPPS_EN_BIT 0
`define TPPS_PRIO_LSB 1
`define TPPS_PRIO_MSB 5
`define TPPS_SRC_LSB 0
`define TPPS_SRC_MSB 4
`define TPPS_RST_PRIO_EN 8'h00
`define TPPS_RST_SOURCE 8'h00
`define TPPS_RDATA_IDLE 8'h00
`define TPPS_REVERT_MARGIN 5'h07
`define TPPS_NUM_REFS 4
`endif

// *** src/tpps_pkg.sv ***
// Types shared by the profile select modules.
package tpps_pkg;
   typedef logic [4:0] tpps_prio_type;
   typedef logic [4:0] tpps_src_type;
   typedef logic [3:0] tpps_refsel_type;
endpackage

// *** src/tpps_if.sv ***
// Carrier between the register file and the switching decision.
`timescale 1ns/1ps
`default_nettype none
interface tpps_if;
   import tpps_pkg::*;
   logic en;
   tpps_prio_type prio;
   tpps_src_type src;
   tpps_prio_type act_prio;
   logic act_valid;
   logic this_active;
   logic this_valid;
   logic switch_req;
   logic stay;
   tpps_refsel_type ref_sel;
   modport cfg (output en, prio, src, act_prio, act_valid, this_active, this_valid,
                input switch_req, stay, ref_sel);
   modport dec (input en, prio, src, act_prio, act_valid, this_active, this_valid,
                output switch_req, stay, ref_sel);
endinterface
`default_nettype wire

// *** src/tpps_decide.sv ***
// Revertive and nonrevertive switching decision and reference decode for one profile.
`timescale 1ns/1ps
`default_nettype none
`include "tpps_defines.svh"
module tpps_decide
   import tpps_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Configuration and status
   tpps_if.dec bus
);
   typedef struct packed
   {
      logic switch_req;
      logic stay;
      tpps_refsel_type ref_sel;
   } tpps_dec_state_type;

   tpps_dec_state_type st_r;
   tpps_dec_state_type st_nxt;
   tpps_prio_type gap;
   logic eligible;
   logic no_worse;
   logic [`TPPS_NUM_REFS-1:0] ref_hot;

   // =========================================================
   // Reference decode
   // source code decode
   genvar gi;
   generate
      for (gi = 0; gi < `TPPS_NUM_REFS; gi++)
      begin : g_ref
         assign ref_hot[gi] = bus.en && (bus.src == tpps_src_type'(gi));
      end
   endgenerate

   // =========================================================
   // Decision
   always_comb
   begin
      st_nxt = st_r;
      no_worse = bus.prio <= bus.act_prio;
      gap = bus.act_prio - bus.prio;
      eligible = bus.en && bus.this_valid && !bus.this_active;
      st_nxt.switch_req = eligible && (!bus.act_valid ||
                          (no_worse && (gap > `TPPS_REVERT_MARGIN)));
      st_nxt.stay = eligible && bus.act_valid && no_worse && (gap <= `TPPS_REVERT_MARGIN);
      st_nxt.ref_sel = ref_hot;
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign bus.switch_req = st_r.switch_req;
   assign bus.stay = st_r.stay;
   assign bus.ref_sel = st_r.ref_sel;

   // =========================================================
   // Checks
   revert_switch_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (bus.en && bus.this_valid && !bus.this_active && bus.act_valid &&
       (bus.act_prio > bus.prio) && (bus.act_prio - bus.prio > `TPPS_REVERT_MARGIN))
      |=> bus.switch_req)
      else $error("better profile beyond margin not switched to");
   nonrevert_stay_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (bus.act_valid && (bus.act_prio >= bus.prio) &&
       (bus.act_prio - bus.prio <= `TPPS_REVERT_MARGIN))
      |=> !bus.switch_req)
      else $error("switch requested inside margin");
   disabled_unused_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !bus.en |=> (bus.ref_sel == '0) && !bus.switch_req && !bus.stay)
      else $error("disabled profile used");
   worse_noswitch_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (bus.act_valid && (bus.prio > bus.act_prio)) |=> !bus.switch_req && !bus.stay)
      else $error("worse priority treated as better");
   src_decode_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (bus.en && bus.src < `TPPS_NUM_REFS) |=> bus.ref_sel == (4'h1 << $past(bus.src[1:0])))
      else $error("reference decode wrong");
   exclusive_dec_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !(bus.switch_req && bus.stay))
      else $error("switch and stay together");
   switch_seen_c: cover property (@(posedge clk_in) disable iff (!rst_b_in) bus.switch_req);
   stay_seen_c: cover property (@(posedge clk_in) disable iff (!rst_b_in) bus.stay);
   ref_last_c: cover property (@(posedge clk_in) disable iff (!rst_b_in) bus.ref_sel[3]);
endmodule // tpps_decide
`default_nettype wire

// *** src/tpps_top.sv ***
// Register file and top level of the translation profile priority select block.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "tpps_defines.svh"
module tpps_top
   import tpps_pkg::*;
#(
   parameter int PRIO_W = 5,
   parameter int SRC_W = 5
)
(
   // Clock and reset
   input wire logic MCLK_IN,
   input wire logic RST_B_IN,
   // Register port
   input wire logic [`TPPS_ADDR_W-1:0] ADDR_IN,
   input wire logic [`TPPS_DATA_W-1:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [`TPPS_DATA_W-1:0] RDATA_OUT,
   // Channel state machine status
   input wire logic [4:0] ACTIVE_PRIO_IN,
   input wire logic ACTIVE_VALID_IN,
   input wire logic THIS_ACTIVE_IN,
   input wire logic THIS_VALID_IN,
   // Decision and reference select
   output logic SWITCH_REQ_OUT,
   output logic STAY_OUT,
   output logic ENABLED_OUT,
   output logic [4:0] PRIORITY_OUT,
   output logic [3:0] REF_SEL_OUT
);
   // =========================================================
   // Parameter check
   generate
      if (PRIO_W != 5 || SRC_W != 5)
      begin : g_bad
         $error("tpps_top supports only five-bit priority and source fields");
      end
   endgenerate

   typedef struct packed
   {
      logic [`TPPS_DATA_W-1:0] prio_en;
      logic [`TPPS_DATA_W-1:0] source;
      logic [`TPPS_DATA_W-1:0] rdata;
   } tpps_reg_state_type;

   tpps_reg_state_type st_r;
   tpps_reg_state_type st_nxt;
   tpps_if link ();

   // =========================================================
   // Register file
   // Reserved bits are never stored, so they read back as zero without a mask on read.
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rdata = `TPPS_RDATA_IDLE;
      if (WR_IN)
      begin
         if (ADDR_IN == `TPPS_ADDR_PRIO_EN)
         begin
            st_nxt.prio_en = '0;
            st_nxt.prio_en[`TPPS_PRIO_MSB:`TPPS_PRIO_LSB] =
               WDATA_IN[`TPPS_PRIO_MSB:`TPPS_PRIO_LSB];
            st_nxt.prio_en[`TPPS_EN_BIT] = WDATA_IN[`TPPS_EN_BIT];
         end
         if (ADDR_IN == `TPPS_ADDR_SOURCE)
         begin
            st_nxt.source = '0;
            st_nxt.source[`TPPS_SRC_MSB:`TPPS_SRC_LSB] = WDATA_IN[`TPPS_SRC_MSB:`TPPS_SRC_LSB];
         end
      end
      if (RD_IN)
      begin
         if (ADDR_IN == `TPPS_ADDR_PRIO_EN)
            st_nxt.rdata = st_r.prio_en;
         else if (ADDR_IN == `TPPS_ADDR_SOURCE)
            st_nxt.rdata = st_r.source;
      end
   end

   always_ff @(posedge MCLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         st_r.prio_en <= `TPPS_RST_PRIO_EN;
         st_r.source <= `TPPS_RST_SOURCE;
         st_r.rdata <= `TPPS_RDATA_IDLE;
      end
      else
         st_r <= st_nxt;
   end

   // =========================================================
   // Decision
   // enable to selector
   assign link.en = st_r.prio_en[`TPPS_EN_BIT];
   assign link.prio = st_r.prio_en[`TPPS_PRIO_MSB:`TPPS_PRIO_LSB];
   assign link.src = st_r.source[`TPPS_SRC_MSB:`TPPS_SRC_LSB];
   assign link.act_prio = ACTIVE_PRIO_IN;
   assign link.act_valid = ACTIVE_VALID_IN;
   assign link.this_active = THIS_ACTIVE_IN;
   assign link.this_valid = THIS_VALID_IN;

   tpps_decide u_decide
   (
      .clk_in(MCLK_IN),
      .rst_b_in(RST_B_IN),
      .bus(link)
   );

   assign RDATA_OUT = st_r.rdata;
   assign SWITCH_REQ_OUT = link.switch_req;
   assign STAY_OUT = link.stay;
   assign REF_SEL_OUT = link.ref_sel;
   assign ENABLED_OUT = st_r.prio_en[`TPPS_EN_BIT];
   assign PRIORITY_OUT = st_r.prio_en[`TPPS_PRIO_MSB:`TPPS_PRIO_LSB];

   // =========================================================
   // Checks
   rd_one_cycle_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (RD_IN && ADDR_IN == `TPPS_ADDR_PRIO_EN) |=> RDATA_OUT == $past(st_r.prio_en))
      else $error("priority readback wrong");
   prio_write_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (WR_IN && ADDR_IN == `TPPS_ADDR_PRIO_EN)
      |=> PRIORITY_OUT == $past(WDATA_IN[`TPPS_PRIO_MSB:`TPPS_PRIO_LSB]))
      else $error("priority write lost");
   enable_write_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (WR_IN && ADDR_IN == `TPPS_ADDR_PRIO_EN && !WDATA_IN[`TPPS_EN_BIT])
      |=> ##1 REF_SEL_OUT == '0)
      else $error("disabled profile still selects a reference");
   src_reserved_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      st_r.source[`TPPS_DATA_W-1:`TPPS_SRC_MSB+1] == '0)
      else $error("reserved source bits set");
   rd_idle_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      !RD_IN |=> RDATA_OUT == `TPPS_RDATA_IDLE)
      else $error("read data outside read answer");
   prio_read_c: cover property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (WR_IN && ADDR_IN == `TPPS_ADDR_PRIO_EN) ##1 (RD_IN && ADDR_IN == `TPPS_ADDR_PRIO_EN));
endmodule // tpps_top
`default_nettype wire

// *** tb/test_tpps_top.sv ***
// Self-checking bench for the translation profile priority select block.
`timescale 1ns/1ps
`default_nettype none
module test_tpps_top;
   import tpps_pkg::*;
   // ==========================================
   // Stimulus, outputs and bookkeeping
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [4:0] act_prio = 5'h00;
   logic act_valid = 1'b0;
   logic this_act = 1'b0;
   logic this_valid = 1'b0;
   logic [7:0] rdata;
   logic switch_req, stay, enabled;
   logic [4:0] prio_o;
   logic [3:0] ref_sel;
   logic [11:0] dec_seen;
   logic rd_q = 1'b0;
   logic chk = 1'b0;
   logic [7:0] exp_rd_q[$];
   logic [11:0] exp_dec_q[$];
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;

   always #12.5 mclk = ~mclk;

   tpps_top dut (.MCLK_IN(mclk), .RST_B_IN(rst_b), .ADDR_IN(addr), .WDATA_IN(wdata),
      .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata), .ACTIVE_PRIO_IN(act_prio),
      .ACTIVE_VALID_IN(act_valid), .THIS_ACTIVE_IN(this_act), .THIS_VALID_IN(this_valid),
      .SWITCH_REQ_OUT(switch_req), .STAY_OUT(stay), .ENABLED_OUT(enabled),
      .PRIORITY_OUT(prio_o), .REF_SEL_OUT(ref_sel));

   assign dec_seen = {switch_req, stay, enabled, prio_o, ref_sel};

   // ==========================================
   // Compare tasks and closing report
   task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e)
      begin
         num_errors++;
         $display("mismatch rdata expected %h seen %h", e, g);
      end
   endtask

   task automatic cmp_dec(input logic [11:0] e, input logic [11:0] g);
      n_compared++;
      if (g !== e)
      begin
         num_errors++;
         $display("mismatch decision expected %h seen %h", e, g);
      end
   endtask

   task automatic end_sim();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ==========================================
   // Output monitor
   // Read data stand only in the cycle after the strobe, so they are taken at that edge.
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 8000)
      begin
         num_errors++;
         end_sim();
      end
      rd_q <= rd_s;
      if (rst_b && rd_q)
         cmp_rd(exp_rd_q.pop_front(), rdata);
      if (chk)
         cmp_dec(exp_dec_q.pop_front(), dec_seen);
   end

   // ==========================================
   // Register bus and decision drivers
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr_s <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge mclk);
      rd_s <= 1'b1;
      addr <= a;
      exp_rd_q.push_back(e);
      @(posedge mclk);
      rd_s <= 1'b0;
   endtask

   // Reserved bits are filled with noise on every write; those of the priority register must read back as zero.
   task automatic dec(input logic e, input logic [4:0] p, input logic [4:0] s,
                      input logic [4:0] ap, input logic av, input logic ta, input logic tv);
      logic el;
      logic [2:0] junk;
      junk = 3'($urandom);
      wr(16'h1600, {junk[1:0], p, e});
      wr(16'h1601, {junk, s});
      rd(16'h1600, {2'b00, p, e});
      @(posedge mclk);
      act_prio <= ap;
      act_valid <= av;
      this_act <= ta;
      this_valid <= tv;
      repeat (3) @(posedge mclk);
      el = e & tv & ~ta;
      exp_dec_q.push_back({el & (~av | (p <= ap && (ap - p) > 5'd7)),
         el & av & (p <= ap) & ((ap - p) <= 5'd7), e, p,
         (e && s < 5'd4) ? 4'(4'h1 << s[1:0]) : 4'h0});
      chk <= 1'b1;
      @(posedge mclk);
      chk <= 1'b0;
   endtask

   // ==========================================
   // Main sequence
   initial
   begin
      void'($urandom(32'h7d0c));
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      rd(16'h1600, 8'h00);
      rd(16'h1601, 8'h00);
      wr(16'h1600, 8'hff);
      wr(16'h1601, 8'hff);
      wr(16'h1602, 8'h00);
      rd(16'h1600, 8'h3f);
      rd(16'h1601, 8'h1f);
      rd(16'h1602, 8'h00);
      // Priorities eight apart revert, seven apart or equal stay, worse holds; then no active, disabled, this active and invalid cases.
      dec(1'b1, 5'd2, 5'd0, 5'd10, 1'b1, 1'b0, 1'b1);
      dec(1'b1, 5'd2, 5'd1, 5'd9, 1'b1, 1'b0, 1'b1);
      dec(1'b1, 5'd9, 5'd2, 5'd9, 1'b1, 1'b0, 1'b1);
      dec(1'b1, 5'd10, 5'd3, 5'd9, 1'b1, 1'b0, 1'b1);
      dec(1'b1, 5'd0, 5'd0, 5'd31, 1'b1, 1'b0, 1'b1);
      dec(1'b1, 5'd5, 5'd1, 5'd5, 1'b0, 1'b0, 1'b1);
      dec(1'b0, 5'd2, 5'd2, 5'd10, 1'b1, 1'b0, 1'b1);
      dec(1'b1, 5'd2, 5'd0, 5'd10, 1'b1, 1'b1, 1'b1);
      dec(1'b1, 5'd2, 5'd0, 5'd10, 1'b1, 1'b0, 1'b0);
      for (int s = 0; s < 6; s++)
         dec(1'b1, 5'd3, (s == 5) ? 5'd31 : 5'(s), 5'd20, 1'b1, 1'b0, 1'b1);
      repeat (60)
         dec(1'($urandom), 5'($urandom), 5'($urandom % 6), 5'($urandom), 1'($urandom),
             1'($urandom), 1'($urandom));
      repeat (3) @(posedge mclk);
      end_sim();
   end
endmodule // test_tpps_top
`default_nettype wire
